// ### hdl/tsr_timer_regs.sv
// Purpose: Interrupt enables, flags, status, counter value and period of a timer/counter.
// Assumes: Match, capture and compare-read events come from logic on the same clock.
// Notes:   Count writes take a fixed number of cycles to land, shown by the busy bit.
//
// Local design decision: the address-and-strobe port.
`default_nettype none

// Overview of operation
// - enable-set one sets channel match enable
// - enable-set sync bit one clears sync enable
// - enable-set one enables error interrupt
// - enable-set one enables overflow interrupt
// - match or capture sets channel flag
// - channel flag requests only when enabled
// - writing one clears channel flag
// - compare register read clears flag in capture
// - capture onto set flag sets error
// - writing one clears error flag
// - overflow sets flag, requests when enabled
// - writing one clears overflow flag
// - busy set during count synchronisation
// - slave bit while master in 32-bit
// - stopped bit when disabled, stopped, single-run
// - counter readable, writable, width per mode
// - count writes synchronised and write-protected
// - period resets ones, loads buffer on update
// - enable-clear clears, both read same
module tsr_timer_regs (
  input  wire logic        CLK_I,        // Clock, 10 MHz.
  input  wire logic        RSTN_I,       // Synchronous reset, active low.
  input  wire logic [7:0]  ADDR_I,       // Byte address.
  input  wire logic [31:0] WDATA_I,      // Write data.
  input  wire logic        WR_I,         // Write strobe.
  input  wire logic        RD_I,         // Read strobe.
  output logic      [31:0] RDATA_O,      // Read data, cycle after the strobe.
  input  wire logic        WPROT_I,      // Peripheral write guard active.
  input  wire logic        CNT_TICK_I,   // Counting tick from the prescaler.
  input  wire logic [1:0]  MATCH_I,      // Compare match per channel.
  input  wire logic [1:0]  CAPTURE_I,    // New capture per channel.
  input  wire logic [1:0]  CAPT_EN_I,    // Channel is in capture operation.
  input  wire logic [1:0]  CC_READ_I,    // Compare/capture value read per channel.
  input  wire logic        SLAVE_UNIT_I, // This timer is the slave of a pair.
  input  wire logic        MASTER32_I,   // Paired master runs in 32-bit mode.
  output logic [1:0]       MC_IRQ_O,     // Channel interrupt requests.
  output logic             ERR_IRQ_O,    // Error interrupt request.
  output logic             OVF_IRQ_O,    // Overflow interrupt request.
  output logic             SYNC_IRQ_O    // Sync ready interrupt request.
);

  logic [7:0]  int_en_q;
  logic [7:0]  flags_q;
  logic [7:0]  flags_d;
  logic [3:0]  ctrl_q;
  logic        stop_latch_q;
  logic [31:0] count_q;
  logic [31:0] count_pend_q;
  logic [7:0]  per_q;
  logic [7:0]  period_buffer_q;
  logic [2:0]  sync_cnt_q;
  logic [31:0] rdata_q;
  tsr_pkg::tsr_sync_e sync_q;

  logic        wr_ctrl, wr_enclr, wr_enset, wr_flags, wr_count, wr_per, wr_period_buffer;
  logic        sync_done, running, at_top, ovf_evt, start_cmd, stop_cmd;
  logic [1:0]  mc_set, err_hit;
  logic [31:0] count_mask, count_top;
  logic [7:0]  status;
  logic [31:0] rd_mux;
  tsr_pkg::tsr_mode_e mode;

  assign wr_ctrl   = WR_I && (ADDR_I == (tsr_pkg::TSR_IDX_CTRL << 2));
  assign wr_enclr  = WR_I && (ADDR_I == (tsr_pkg::TSR_IDX_ENCLR << 2)) && !WPROT_I;
  assign wr_enset  = WR_I && (ADDR_I == (tsr_pkg::TSR_IDX_ENSET << 2)) && !WPROT_I;
  assign wr_flags  = WR_I && (ADDR_I == (tsr_pkg::TSR_IDX_FLAGS << 2));
  assign wr_count  = WR_I && (ADDR_I == (tsr_pkg::TSR_IDX_COUNT << 2)) && !WPROT_I;
  assign wr_per    = WR_I && (ADDR_I == (tsr_pkg::TSR_IDX_PER << 2));
  assign wr_period_buffer = WR_I && (ADDR_I == (tsr_pkg::TSR_IDX_PERIOD_BUFFER << 2));

  assign mode = tsr_pkg::tsr_mode_e'(ctrl_q[tsr_pkg::TSR_C_MODE +: 2]);
  assign start_cmd = wr_ctrl && WDATA_I[tsr_pkg::TSR_C_START];
  assign stop_cmd  = wr_ctrl && WDATA_I[tsr_pkg::TSR_C_STOP];

  // Control: enable, mode and single-run are stored; start and stop are pulses.
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      ctrl_q <= 4'h0;
    end else if (wr_ctrl) begin
      ctrl_q <= WDATA_I[3:0];
    end
  end

  // The stop latch also catches the single-run overflow.
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      stop_latch_q <= 1'b0;
    end else if (stop_cmd || (ovf_evt && ctrl_q[tsr_pkg::TSR_C_ONE])) begin
      stop_latch_q <= 1'b1;
    end else if (start_cmd) begin
      stop_latch_q <= 1'b0;
    end
  end

  assign running = ctrl_q[tsr_pkg::TSR_C_EN] && !stop_latch_q;

  // Interrupt enables: one register seen through the set and clear addresses.
  // Both addresses clear the sync-ready enable, so it can never be raised and its
  // request output stays low; this is deliberate, not an omission.
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      int_en_q <= tsr_pkg::TSR_RST_EN;
    end else if (wr_enset) begin
      int_en_q[tsr_pkg::TSR_B_MC1:tsr_pkg::TSR_B_MC0] <= int_en_q[5:4] | WDATA_I[5:4];
      int_en_q[tsr_pkg::TSR_B_SYNC] <= int_en_q[3] & ~WDATA_I[3];
      int_en_q[tsr_pkg::TSR_B_ERR] <= int_en_q[1] | WDATA_I[1];
      int_en_q[tsr_pkg::TSR_B_OVF] <= int_en_q[0] | WDATA_I[0];
    end else if (wr_enclr) begin
      int_en_q <= int_en_q & ~(WDATA_I[7:0] & tsr_pkg::TSR_IRQ_MASK);
    end
  end

  // Flag events. A capture onto a still-set channel flag has nowhere to go.
  assign mc_set  = MATCH_I | CAPTURE_I;
  assign err_hit = CAPTURE_I & flags_q[5:4];

  always_comb begin
    flags_d = flags_q;
    if (wr_flags) begin
      flags_d = flags_d & ~(WDATA_I[7:0] & tsr_pkg::TSR_IRQ_MASK);
    end
    flags_d[5:4] = flags_d[5:4] & ~(CC_READ_I & CAPT_EN_I);
    // Set events are applied last so that they win over any clear.
    flags_d[5:4] = flags_d[5:4] | mc_set;
    flags_d[tsr_pkg::TSR_B_ERR]  = flags_d[1] | (|err_hit);
    flags_d[tsr_pkg::TSR_B_OVF]  = flags_d[0] | ovf_evt;
    flags_d[tsr_pkg::TSR_B_SYNC] = flags_d[3] | sync_done;
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      flags_q <= tsr_pkg::TSR_RST_FLAGS;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign MC_IRQ_O   = flags_q[5:4] & int_en_q[5:4];
  assign ERR_IRQ_O  = flags_q[1] & int_en_q[1];
  assign OVF_IRQ_O  = flags_q[0] & int_en_q[0];
  assign SYNC_IRQ_O = flags_q[3] & int_en_q[3];

  // Count write synchronisation; a second write during busy restarts it.
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      sync_q       <= tsr_pkg::TSR_SYNC_IDLE;
      sync_cnt_q   <= 3'h0;
      count_pend_q <= tsr_pkg::TSR_RST_COUNT;
    end else if (wr_count) begin
      sync_q       <= tsr_pkg::TSR_SYNC_BUSY;
      sync_cnt_q   <= tsr_pkg::TSR_SYNC_CYCLES - 3'h1;
      count_pend_q <= WDATA_I;
    end else begin
      case (sync_q)
        tsr_pkg::TSR_SYNC_BUSY: begin
          if (sync_cnt_q == 3'h0) begin
            sync_q <= tsr_pkg::TSR_SYNC_IDLE;
          end else begin
            sync_cnt_q <= sync_cnt_q - 3'h1;
          end
        end
        default: sync_q <= tsr_pkg::TSR_SYNC_IDLE;
      endcase
    end
  end

  assign sync_done = (sync_q == tsr_pkg::TSR_SYNC_BUSY) && (sync_cnt_q == 3'h0) && !wr_count;

  // Counter width and top value follow the mode.
  always_comb begin
    case (mode)
      tsr_pkg::TSR_MODE8: begin
        count_mask = 32'h0000_00ff;
        count_top  = {24'h00_0000, per_q};
      end
      tsr_pkg::TSR_MODE32: begin
        count_mask = 32'hffff_ffff;
        count_top  = 32'hffff_ffff;
      end
      default: begin
        count_mask = 32'h0000_ffff;
        count_top  = 32'h0000_ffff;
      end
    endcase
  end

  assign at_top  = (count_q & count_mask) == count_top;
  assign ovf_evt = running && CNT_TICK_I && at_top && !sync_done;

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      count_q <= tsr_pkg::TSR_RST_COUNT;
    end else if (sync_done) begin
      count_q <= count_pend_q & count_mask;
    end else if (running && CNT_TICK_I) begin
      count_q <= at_top ? 32'h0000_0000 : ((count_q + 32'h1) & count_mask);
    end
  end

  // Period and its buffer; an overflow is the update condition.
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      per_q    <= tsr_pkg::TSR_RST_PER;
      period_buffer_q <= tsr_pkg::TSR_RST_PER;
    end else begin
      if (wr_period_buffer) begin
        period_buffer_q <= WDATA_I[7:0];
      end
      if (ovf_evt) begin
        per_q <= period_buffer_q;
      end else if (wr_per) begin
        per_q <= WDATA_I[7:0];
      end
    end
  end

  always_comb begin
    status = 8'h00;
    status[tsr_pkg::TSR_B_BUSY]  = (sync_q == tsr_pkg::TSR_SYNC_BUSY);
    status[tsr_pkg::TSR_B_SLAVE] = SLAVE_UNIT_I && MASTER32_I;
    status[tsr_pkg::TSR_B_STOP]  = !running;
  end

  // Count reads return the live value; only writes go through the crossing.
  always_comb begin
    case (ADDR_I)
      tsr_pkg::TSR_IDX_CTRL << 2:   rd_mux = {26'h0, 2'b00, ctrl_q[3:0]};
      tsr_pkg::TSR_IDX_ENCLR << 2:  rd_mux = {24'h0, int_en_q};
      tsr_pkg::TSR_IDX_ENSET << 2:  rd_mux = {24'h0, int_en_q};
      tsr_pkg::TSR_IDX_FLAGS << 2:  rd_mux = {24'h0, flags_q};
      tsr_pkg::TSR_IDX_STATUS << 2: rd_mux = {24'h0, status};
      tsr_pkg::TSR_IDX_COUNT << 2:  rd_mux = count_q & count_mask;
      tsr_pkg::TSR_IDX_PER << 2:    rd_mux = {24'h0, per_q};
      tsr_pkg::TSR_IDX_PERIOD_BUFFER << 2: rd_mux = {24'h0, period_buffer_q};
      default:                      rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data stands for one cycle only, zero otherwise.
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= RD_I ? rd_mux : 32'h0000_0000;
    end
  end

  assign RDATA_O = rdata_q;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  AST_ENSET_MC: assert property (
    wr_enset && WDATA_I[4] |=> int_en_q[4])
    else $error("Channel 0 enable not set by enable-set write.");
  AST_ENSET_SYNC: assert property (
    wr_enset && WDATA_I[3] |=> !int_en_q[3] && !SYNC_IRQ_O)
    else $error("Sync ready enable not cleared.");
  AST_ENSET_ERR: assert property (
    wr_enset && !WDATA_I[1] |=> int_en_q[1] == $past(int_en_q[1]))
    else $error("Error enable changed by a zero write.");
  AST_ENSET_OVF: assert property (
    wr_enset && WDATA_I[0] |=> int_en_q[0] && (OVF_IRQ_O == flags_q[0]))
    else $error("Overflow enable not set.");
  AST_MC_SET: assert property (
    MATCH_I[1] |=> flags_q[5])
    else $error("Match did not set channel 1 flag.");
  AST_ERR_SET: assert property (
    CAPTURE_I[0] && flags_q[4] |=> flags_q[1] && ERR_IRQ_O == int_en_q[1])
    else $error("Capture overrun did not set error flag.");
  AST_OVF_CLR: assert property (
    wr_flags && WDATA_I[0] && !ovf_evt |=> !flags_q[0] && !OVF_IRQ_O)
    else $error("Overflow flag not cleared by one write.");
  AST_SET_WINS: assert property (
    wr_flags && WDATA_I[4] && MATCH_I[0] |=> flags_q[4])
    else $error("Clear beat a same-cycle set.");
  AST_SYNC_BUSY: assert property (
    wr_count ##1 !wr_count [*3] |-> status[7] ##1 !status[7] ##0
      (count_q == ($past(count_pend_q) & count_mask)))
    else $error("Busy window or count load wrong.");
  AST_PER_LOAD: assert property (
    ovf_evt |=> per_q == $past(period_buffer_q) && flags_q[0])
    else $error("Period not loaded on update.");
  AST_STOPPED: assert property (
    !ctrl_q[0] |-> status[3])
    else $error("Stopped bit low while disabled.");
  AST_CC_READ: assert property (
    CC_READ_I[0] && CAPT_EN_I[0] && !mc_set[0] |=> !flags_q[4])
    else $error("Compare read did not clear flag.");

  // Enable register paths and the write guard.
  AST_ENSET_MC1: assert property (
    wr_enset && WDATA_I[5] |=> int_en_q[5])
    else $error("Channel 1 enable not set by enable-set write.");
  AST_ENSET_KEEP: assert property (
    wr_enset && !WDATA_I[4] |=> int_en_q[4] == $past(int_en_q[4]))
    else $error("Channel 0 enable changed by a zero write.");
  AST_ENCLR: assert property (
    wr_enclr && WDATA_I[4] |=> !int_en_q[4])
    else $error("Enable-clear write left channel 0 enabled.");
  AST_GUARD_EN: assert property (
    WPROT_I |=> int_en_q == $past(int_en_q))
    else $error("Enables changed while writes are guarded.");

  // Flag set, clear and request paths.
  AST_MC_IRQ: assert property (
    MATCH_I[1] && int_en_q[5] && !wr_enclr |=> MC_IRQ_O[1])
    else $error("Enabled channel 1 match raised no request.");
  AST_MC_CLR: assert property (
    wr_flags && WDATA_I[5] && !mc_set[1] |=> !flags_q[5])
    else $error("Channel 1 flag not cleared by one write.");
  AST_MC_KEEP: assert property (
    wr_flags && !WDATA_I[4] && flags_q[4] && !CC_READ_I[0] |=> flags_q[4])
    else $error("Channel 0 flag cleared by a zero write.");
  AST_CC_KEEP: assert property (
    CC_READ_I[0] && !CAPT_EN_I[0] && flags_q[4] && !(wr_flags && WDATA_I[4])
      |=> flags_q[4])
    else $error("Compare read cleared a flag outside capture.");
  AST_ERR_CLR: assert property (
    wr_flags && WDATA_I[1] && !(|err_hit) |=> !flags_q[1])
    else $error("Error flag not cleared by one write.");
  AST_OVF_SET: assert property (
    ovf_evt |=> flags_q[0] && (OVF_IRQ_O == int_en_q[0]))
    else $error("Overflow flag or request wrong after overflow.");
  AST_IRQ_DROP: assert property (
    wr_flags && WDATA_I[5] && !mc_set[1] |=> !MC_IRQ_O[1])
    else $error("Channel 1 request stayed up after its flag cleared.");

  // Synchronisation, counting, period and stop state.
  AST_BUSY_RISE: assert property (
    wr_count |=> status[tsr_pkg::TSR_B_BUSY])
    else $error("Busy bit not set by a count write.");
  AST_SYNC_FLAG: assert property (
    sync_done |=> flags_q[tsr_pkg::TSR_B_SYNC])
    else $error("Sync ready flag not set at completion.");
  AST_GUARD_CNT: assert property (
    WPROT_I && (sync_q == tsr_pkg::TSR_SYNC_IDLE) |=> sync_q == tsr_pkg::TSR_SYNC_IDLE)
    else $error("Guarded count write started a synchronisation.");
  AST_COUNT8: assert property (
    (mode == tsr_pkg::TSR_MODE8) && running && CNT_TICK_I && !sync_done
      |=> count_q[31:8] == 24'h00_0000)
    else $error("Upper count bits set in 8-bit mode.");
  AST_PER_HOLD: assert property (
    !ovf_evt && !wr_per |=> per_q == $past(per_q))
    else $error("Period changed without update or write.");
  AST_STOP_CMD: assert property (
    stop_cmd |=> status[tsr_pkg::TSR_B_STOP])
    else $error("Stopped bit low after a stop command.");
  AST_SINGLE_RUN: assert property (
    ovf_evt && ctrl_q[tsr_pkg::TSR_C_ONE] |=> status[tsr_pkg::TSR_B_STOP])
    else $error("Stopped bit low after a single-run overflow.");
  AST_START: assert property (
    start_cmd && !stop_cmd && !ovf_evt && WDATA_I[tsr_pkg::TSR_C_EN]
      |=> !status[tsr_pkg::TSR_B_STOP])
    else $error("Stopped bit high after an enabling start.");

  COV_OVF_IRQ:  cover property (running && CNT_TICK_I && at_top && int_en_q[0] ##1 OVF_IRQ_O);
  COV_OVERRUN:  cover property (CAPTURE_I[1] && flags_q[5]);
  COV_SYNC:     cover property (wr_count ##[3:4] sync_done);
  COV_SINGLE_RUN:  cover property (ovf_evt && ctrl_q[3] ##1 status[3]);
  COV_SET_WINS: cover property (wr_flags && WDATA_I[4] && MATCH_I[0]);

endmodule : tsr_timer_regs
`default_nettype wire

// ### pkg/tsr_pkg.sv
// Purpose: Constants and types for the timer interrupt, status, count and period registers.
// Assumes: One clock at 10 MHz; register bus byte address is four times the register index.
// Notes:   Every offset, field position and cycle count lives here, and every reset value but the control register's.
`default_nettype none
package tsr_pkg;

  localparam int unsigned TSR_DW = 32;
  localparam int unsigned TSR_AW = 8;

  // Register indices; the byte address is the index times four.
  localparam logic [TSR_AW-1:0] TSR_IDX_CTRL   = 8'h00;
  localparam logic [TSR_AW-1:0] TSR_IDX_ENCLR  = 8'h0c;
  localparam logic [TSR_AW-1:0] TSR_IDX_ENSET  = 8'h0d;
  localparam logic [TSR_AW-1:0] TSR_IDX_FLAGS  = 8'h0e;
  localparam logic [TSR_AW-1:0] TSR_IDX_STATUS = 8'h0f;
  localparam logic [TSR_AW-1:0] TSR_IDX_COUNT  = 8'h10;
  localparam logic [TSR_AW-1:0] TSR_IDX_PER    = 8'h14;
  localparam logic [TSR_AW-1:0] TSR_IDX_PERIOD_BUFFER = 8'h20;

  // Interrupt enable and flag bit positions.
  localparam int unsigned TSR_B_OVF  = 0;
  localparam int unsigned TSR_B_ERR  = 1;
  localparam int unsigned TSR_B_SYNC = 3;
  localparam int unsigned TSR_B_MC0  = 4;
  localparam int unsigned TSR_B_MC1  = 5;
  localparam logic [7:0]  TSR_IRQ_MASK = 8'h3b;

  // Status bit positions.
  localparam int unsigned TSR_B_STOP  = 3;
  localparam int unsigned TSR_B_SLAVE = 4;
  localparam int unsigned TSR_B_BUSY  = 7;

  // Control register fields.
  localparam int unsigned TSR_C_EN    = 0;
  localparam int unsigned TSR_C_MODE  = 1;
  localparam int unsigned TSR_C_ONE   = 3;
  localparam int unsigned TSR_C_STOP  = 4;
  localparam int unsigned TSR_C_START = 5;

  // Reset values.
  localparam logic [7:0]  TSR_RST_EN     = 8'h00;
  localparam logic [7:0]  TSR_RST_FLAGS  = 8'h00;
  localparam logic [7:0]  TSR_RST_STATUS = 8'h08;
  localparam logic [31:0] TSR_RST_COUNT  = 32'h0000_0000;
  localparam logic [7:0]  TSR_RST_PER    = 8'hff;

  // Cycles that a count write spends crossing into the counting logic.
  localparam logic [2:0]  TSR_SYNC_CYCLES = 3'h3;

  typedef enum logic [1:0] {
    TSR_MODE16 = 2'b00,
    TSR_MODE8  = 2'b01,
    TSR_MODE32 = 2'b10
  } tsr_mode_e;

  typedef enum logic {
    TSR_SYNC_IDLE = 1'b0,
    TSR_SYNC_BUSY = 1'b1
  } tsr_sync_e;

endpackage : tsr_pkg
`default_nettype wire

// ### tb/tsr_timer_regs_bench.sv
// Purpose: Self-checking bench for the timer interrupt, status, count and period registers.
// Assumes: Bus strobes are one cycle wide and read data stand only in the cycle after the strobe.
// Notes:   Flag masks leave out the sync-ready bit wherever a count write may have set it.
`default_nettype none
module tsr_timer_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] A_CTRL = {tsr_pkg::TSR_IDX_CTRL[5:0], 2'b00};
  localparam logic [7:0] A_ENC  = {tsr_pkg::TSR_IDX_ENCLR[5:0], 2'b00};
  localparam logic [7:0] A_ENS  = {tsr_pkg::TSR_IDX_ENSET[5:0], 2'b00};
  localparam logic [7:0] A_FLG  = {tsr_pkg::TSR_IDX_FLAGS[5:0], 2'b00};
  localparam logic [7:0] A_STA  = {tsr_pkg::TSR_IDX_STATUS[5:0], 2'b00};
  localparam logic [7:0] A_CNT  = {tsr_pkg::TSR_IDX_COUNT[5:0], 2'b00};
  localparam logic [7:0] A_PER  = {tsr_pkg::TSR_IDX_PER[5:0], 2'b00};
  localparam logic [7:0] A_PBF  = {tsr_pkg::TSR_IDX_PERIOD_BUFFER[5:0], 2'b00};
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        wprot = 1'b0;
  logic        tick = 1'b0;
  logic [1:0]  match = 2'h0;
  logic [1:0]  capt = 2'h0;
  logic [1:0]  capt_en = 2'h0;
  logic [1:0]  cc_rd = 2'h0;
  logic        slave = 1'b0;
  logic        m32 = 1'b0;
  logic [1:0]  mc_irq;
  logic        err_irq;
  logic        ovf_irq;
  logic        sync_irq;
  int          bad_count = 0;
  int          total_checks = 0;

  tsr_timer_regs u_tsr_timer_regs (
    .CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .WPROT_I(wprot), .CNT_TICK_I(tick), .MATCH_I(match),
    .CAPTURE_I(capt), .CAPT_EN_I(capt_en), .CC_READ_I(cc_rd), .SLAVE_UNIT_I(slave),
    .MASTER32_I(m32), .MC_IRQ_O(mc_irq), .ERR_IRQ_O(err_irq), .OVF_IRQ_O(ovf_irq),
    .SYNC_IRQ_O(sync_irq)
  );

  always #50 clk = ~clk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // Read data are sampled just after the taking edge, before the next edge clears them.
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk(nm, rdata & m, exp);
  endtask : rd_chk

  task automatic ev(input logic [1:0] m, input logic [1:0] c, input logic [1:0] r);
    @(posedge clk);
    match <= m;
    capt  <= c;
    cc_rd <= r;
    @(posedge clk);
    match <= 2'h0;
    capt  <= 2'h0;
    cc_rd <= 2'h0;
    @(posedge clk);
    #1;
  endtask : ev

  task automatic t_reset();
    rd_chk("flags", A_FLG, 32'hffffffff, 32'h0000_0000);
    rd_chk("status", A_STA, 32'hffffffff, 32'h0000_0008);
    rd_chk("count", A_CNT, 32'hffffffff, 32'h0000_0000);
    rd_chk("period", A_PER, 32'hffffffff, 32'h0000_00ff);
    rd_chk("enset", A_ENS, 32'hffffffff, 32'h0000_0000);
    rd_chk("unmapped", 8'h44, 32'hffffffff, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_enable();
    wr_reg(A_ENS, 32'h0000_003b);
    rd_chk("enset", A_ENS, 32'h0000_0033, 32'h0000_0033);
    rd_chk("sync_en", A_ENS, 32'h0000_0008, 32'h0000_0000);
    chk("sync_irq", {31'h0, sync_irq}, 32'h0000_0000);
    wr_reg(A_ENS, 32'h0000_0000);
    rd_chk("enset_zero", A_ENS, 32'h0000_00ff, 32'h0000_0033);
    wr_reg(A_ENC, 32'h0000_0011);
    rd_chk("enset_after_clr", A_ENS, 32'h0000_00ff, 32'h0000_0022);
    rd_chk("enclr_after_clr", A_ENC, 32'h0000_00ff, 32'h0000_0022);
    $display("test enable done");
  endtask : t_enable

  task automatic t_match();
    ev(2'b11, 2'b00, 2'b00);
    rd_chk("mc_flags", A_FLG, 32'h0000_0033, 32'h0000_0030);
    chk("mc_irq", {30'h0, mc_irq}, 32'h0000_0002);
    wr_reg(A_FLG, 32'h0000_0020);
    rd_chk("mc_clear", A_FLG, 32'h0000_0033, 32'h0000_0010);
    chk("mc_irq_clr", {30'h0, mc_irq}, 32'h0000_0000);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= A_FLG;
    wdata <= 32'h0000_0010;
    match <= 2'b01;
    @(posedge clk);
    wr    <= 1'b0;
    match <= 2'b00;
    rd_chk("set_wins", A_FLG, 32'h0000_0033, 32'h0000_0010);
    ev(2'b00, 2'b00, 2'b01);
    rd_chk("cc_rd_compare", A_FLG, 32'h0000_0010, 32'h0000_0010);
    wr_reg(A_FLG, 32'h0000_0010);
    $display("test match done");
  endtask : t_match

  task automatic t_capture();
    @(posedge clk);
    capt_en <= 2'b11;
    ev(2'b00, 2'b01, 2'b00);
    ev(2'b00, 2'b01, 2'b00);
    rd_chk("overrun", A_FLG, 32'h0000_0033, 32'h0000_0012);
    chk("err_irq", {31'h0, err_irq}, 32'h0000_0001);
    ev(2'b00, 2'b00, 2'b01);
    rd_chk("cc_read_clr", A_FLG, 32'h0000_0010, 32'h0000_0000);
    wr_reg(A_FLG, 32'h0000_0002);
    rd_chk("err_clr", A_FLG, 32'h0000_0002, 32'h0000_0000);
    chk("err_irq_clr", {31'h0, err_irq}, 32'h0000_0000);
    @(posedge clk);
    capt_en <= 2'b00;
    $display("test capture done");
  endtask : t_capture

  task automatic t_count();
    wr_reg(A_CNT, 32'h5a5a_1234);
    rd_chk("busy_set", A_STA, 32'h0000_0080, 32'h0000_0080);
    repeat (6) @(posedge clk);
    rd_chk("busy_clr", A_STA, 32'h0000_0080, 32'h0000_0000);
    rd_chk("count_wr", A_CNT, 32'hffffffff, 32'h0000_1234);
    @(posedge clk);
    wprot <= 1'b1;
    wr_reg(A_CNT, 32'h0000_0055);
    wr_reg(A_ENS, 32'h0000_0001);
    repeat (6) @(posedge clk);
    rd_chk("count_guard", A_CNT, 32'hffffffff, 32'h0000_1234);
    rd_chk("enset_guard", A_ENS, 32'h0000_00ff, 32'h0000_0022);
    @(posedge clk);
    wprot <= 1'b0;
    wr_reg(A_CTRL, 32'h0000_0004);
    wr_reg(A_CNT, 32'h89ab_cdef);
    repeat (6) @(posedge clk);
    rd_chk("count32", A_CNT, 32'hffffffff, 32'h89ab_cdef);
    wr_reg(A_CTRL, 32'h0000_0002);
    rd_chk("count8", A_CNT, 32'hffffffff, 32'h0000_00ef);
    $display("test count done");
  endtask : t_count

  task automatic t_run();
    int i;
    wr_reg(A_PBF, 32'h0000_0005);
    wr_reg(A_CNT, 32'h0000_00f0);
    repeat (6) @(posedge clk);
    wr_reg(A_ENS, 32'h0000_0001);
    tick <= 1'b1;
    wr_reg(A_CTRL, 32'h0000_002b);
    rd_chk("running", A_STA, 32'h0000_0008, 32'h0000_0000);
    for (i = 0; i < 60; i++) begin
      @(posedge clk);
      #1;
      if (ovf_irq === 1'b1) break;
    end
    if (i == 60) begin
      bad_count++;
      $display("mismatch ovf_wait expected 1 seen 0");
      print_verdict();
    end
    rd_chk("ovf_flag", A_FLG, 32'h0000_0001, 32'h0000_0001);
    rd_chk("single_run_stop", A_STA, 32'h0000_0008, 32'h0000_0008);
    rd_chk("per_loaded", A_PER, 32'hffffffff, 32'h0000_0005);
    wr_reg(A_FLG, 32'h0000_0001);
    rd_chk("ovf_clr", A_FLG, 32'h0000_0001, 32'h0000_0000);
    chk("ovf_irq_clr", {31'h0, ovf_irq}, 32'h0000_0000);
    wr_reg(A_CTRL, 32'h0000_0023);
    rd_chk("restart", A_STA, 32'h0000_0008, 32'h0000_0000);
    wr_reg(A_CTRL, 32'h0000_0013);
    rd_chk("stop_cmd", A_STA, 32'h0000_0008, 32'h0000_0008);
    wr_reg(A_CTRL, 32'h0000_0000);
    tick <= 1'b0;
    rd_chk("disabled", A_STA, 32'h0000_0008, 32'h0000_0008);
    $display("test run done");
  endtask : t_run

  task automatic t_slave();
    @(posedge clk);
    slave <= 1'b1;
    m32   <= 1'b1;
    rd_chk("slave_on", A_STA, 32'h0000_0010, 32'h0000_0010);
    @(posedge clk);
    m32 <= 1'b0;
    rd_chk("slave_off", A_STA, 32'h0000_0010, 32'h0000_0000);
    @(posedge clk);
    slave <= 1'b0;
    m32   <= 1'b1;
    rd_chk("master_only", A_STA, 32'h0000_0010, 32'h0000_0000);
    $display("test slave done");
  endtask : t_slave

  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_enable();
    t_match();
    t_capture();
    t_count();
    t_run();
    t_slave();
    print_verdict();
  end
endmodule : tsr_timer_regs_bench
`default_nettype wire
